// file: verilog/rst_ctrl_pkg.sv
// constants, types and field layout of the reset and stop-recovery block
// assumes a 32-bit classic Wishbone slave port and a 125 MHz clk_sys
// Behaviour
// - after supply passes power-on level, hold reset until delay counter expires
// - on leaving reset or recovery, fetch start vector from 0002H/0003H
// - power-on or brown-out sequence end sets power-on indicator bit
// - brown-out puts device in reset, held while supply below power-on level
// - supply return after brown-out runs the full reset sequence and delay
// - option bit keeps brown-out detection active or off during stop
// - watchdog time-out resets when action option is 1, else interrupts
// - watchdog-caused reset sets the watchdog indicator bit
// - pin low four cycles always resets; three cycles may
// - pin held low keeps reset; exit on first edge after release (here the third edge, after the two-stage synchroniser)
// - pin-caused reset sets the pin-reset indicator bit
// - reset pin is an active-low open-drain output during reset
// - internal reset drives pin low until its latency has elapsed
// - debugger request resets all but debugger, self-clears, sets power-on bit
// - stop recovery holds processor 66 cycles, or 5000 with crystal
// - stop recovery leaves registers alone except watchdog and oscillator control
// - after stop recovery internal oscillator is enabled and selected
// - every stop recovery sets the stop-recovery indicator bit
// - watchdog in stop recovers, sets both bits, interrupt serviced after only when action option is 0
// - in stop, reset pin or debug pin low gives full reset, reset pin glitches ignored
// - any edge on an enabled port pin in stop starts recovery
// - port inputs off in stop; captured only if level lasts recovery
// - status register at FF0H: bits 7..4 flags, bits 3..0 zero
// - reading the status register clears its four indicator bits
package rst_ctrl_pkg;

	// ========================================
	// register map
	localparam logic [11:0] RSTAT_ADDR = 12'hFF0;
	localparam logic [11:0] CTRL_ADDR = 12'hFF4;
	localparam int CTRL_IND_BIT = 0;
	localparam int FLAG_LSB = 4;

	// ========================================
	// timing
	localparam int CLK_NS = 8;
	localparam int IPO_START_NS = 4000;
	localparam int IPO_START_CYC = (IPO_START_NS + CLK_NS - 1) / CLK_NS;
	localparam int BASE_DLY_CYC = 66;
	localparam int PIN_MIN_CYC = 3;
	localparam int PIN_SETTLE_CYC = 3;
	localparam logic [15:0] START_VECTOR = 16'h0002;

	// ========================================
	// types
	typedef struct packed {
		logic por_flag;
		logic stop_flag;
		logic watchdog_flag;
		logic pin_reset_flag;
	} flags_s;

	localparam flags_s CAUSE_POR = 4'h8;
	localparam flags_s CAUSE_SMR = 4'h4;
	localparam flags_s CAUSE_WDT = 4'h2;
	localparam flags_s CAUSE_PIN = 4'h1;
	localparam flags_s CAUSE_SMR_WDT = 4'h6;
	localparam flags_s CAUSE_NONE = 4'h0;

	typedef enum logic [2:0] {
		ST_HOLD = 3'b000,
		ST_DELAY = 3'b001,
		ST_PINWAIT = 3'b010,
		ST_RUN = 3'b011,
		ST_STOP = 3'b100,
		ST_RECOVER = 3'b101
	} state_e;

endpackage : rst_ctrl_pkg

// file: verilog/rst_ctrl.sv
// reset and low_power_recovery sequencer with Wishbone status port
// assumes supply monitors and pins are asynchronous; cpu pulses are on clk_sys
//
// Chosen here: the Wishbone register port and the address map.
`timescale 1ns/1ns
module rst_ctrl import rst_ctrl_pkg::*; #(
	parameter int XTAL_DELAY_CYC = 5000,
	parameter int GPIO_N = 8
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	// classic Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [11:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// supply monitors and option bits
	input wire logic por_ok,
	input wire logic brown_out_detect,
	input wire logic brown_out_stop_enable_option,
	input wire logic watchdog_action_option,
	input wire logic xtal_enable_option,
	// watchdog, debugger and core
	input wire logic watchdog_timeout,
	input wire logic on_chip_debugger_rst_req,
	input wire logic stop_req,
	input wire logic debug_pin,
	// reset pin, open-drain
	input wire logic rst_pin_n_i,
	output logic rst_pin_n_o,
	output logic rst_pin_n_oe,
	// port pins enabled as recovery sources
	input wire logic [GPIO_N-1:0] gpio_in,
	input wire logic [GPIO_N-1:0] gpio_smr_en,
	// towards core and peripherals
	output logic cpu_rst,
	output logic periph_rst,
	output logic dbg_req_clr,
	output logic vector_fetch,
	output logic [15:0] vector_addr,
	output logic osc_ipo_select,
	output logic wdt_ctl_update,
	output logic wdt_irq,
	output logic port_input_enable,
	output logic port_capture,
	output logic in_stop
);

	// ========================================
	// delay loads
	function automatic logic [15:0] dly_load(input logic xtal,
		input logic full);
		int n;
		n = xtal ? XTAL_DELAY_CYC : BASE_DLY_CYC;
		if (full) begin
			n = n + IPO_START_CYC;
		end
		dly_load = 16'(n - 1);
	endfunction : dly_load

	// ========================================
	// synchronisers
	logic por_s1_ff, por_s2_ff, bo_s1_ff, bo_s2_ff;
	logic pin_s1_ff, pin_s2_ff, dbg_s1_ff, dbg_s2_ff;
	logic [GPIO_N-1:0] gp_s1_ff, gp_s2_ff, gp_prev_ff;

	always_ff @(posedge clk_sys) begin
		por_s1_ff <= por_ok;
		por_s2_ff <= por_s1_ff;
		bo_s1_ff <= brown_out_detect;
		bo_s2_ff <= bo_s1_ff;
		pin_s1_ff <= rst_pin_n_i;
		pin_s2_ff <= pin_s1_ff;
		dbg_s1_ff <= debug_pin;
		dbg_s2_ff <= dbg_s1_ff;
		gp_s1_ff <= gpio_in;
		gp_s2_ff <= gp_s1_ff;
		gp_prev_ff <= gp_s2_ff;
	end

	// ========================================
	// state
	state_e state_ff, nxt_state;
	flags_s cause_ff, nxt_cause, flags_ff, nxt_flags;
	logic [15:0] cnt_ff, nxt_cnt;
	logic [1:0] pin_cnt_ff, nxt_pin_cnt;
	logic [1:0] settle_ff, nxt_settle;
	logic ind_en_ff, ack_ff;
	logic [31:0] dat_ff;
	logic done_ev, smr_done, irq_ev, clr_ev;

	wire stop_like = (state_ff == ST_STOP);
	wire bo_active = bo_s2_ff & (~stop_like | brown_out_stop_enable_option);
	wire power_bad = ~por_s2_ff | bo_active;
	wire pin_low = ~pin_s2_ff;
	wire pin_mask = rst_pin_n_oe | (settle_ff != 2'h0);
	wire pin_req = pin_low & (pin_cnt_ff == 2'(PIN_MIN_CYC));
	wire gpio_edge = |((gp_s2_ff ^ gp_prev_ff) & gpio_smr_en);
	wire cnt_zero = (cnt_ff == 16'h0000);
	wire cause_int = (cause_ff != CAUSE_PIN);

	// bus decode
	wire wb_req = wb_cyc_i & wb_stb_i & ~ack_ff;
	wire hit_stat = (wb_adr_i == RSTAT_ADDR);
	wire hit_ctrl = (wb_adr_i == CTRL_ADDR);
	wire stat_rd = wb_req & ~wb_we_i & hit_stat;
	wire ctrl_wr = wb_req & wb_we_i & hit_ctrl & wb_sel_i[0];

	// ========================================
	// next-state logic
	always_comb begin
		nxt_state = state_ff;
		nxt_cause = cause_ff;
		nxt_cnt = cnt_ff;
		nxt_settle = (settle_ff != 2'h0) ? settle_ff - 2'h1 : 2'h0;
		done_ev = 1'b0;
		smr_done = 1'b0;
		irq_ev = 1'b0;
		clr_ev = 1'b0;
		case (state_ff)
		ST_HOLD: begin
			if (!power_bad) begin
				nxt_state = ST_DELAY;
				nxt_cause = CAUSE_POR;
				nxt_cnt = dly_load(xtal_enable_option, 1'b1);
			end
		end
		ST_DELAY: begin
			if (power_bad) begin
				nxt_state = ST_HOLD;
			end else if (!cnt_zero) begin
				nxt_cnt = cnt_ff - 16'h0001;
			end else begin
				nxt_state = ST_PINWAIT;
				nxt_settle = 2'(PIN_SETTLE_CYC);
			end
		end
		ST_PINWAIT: begin
			if (power_bad) begin
				nxt_state = ST_HOLD;
			end else if (settle_ff == 2'h0 && !pin_low) begin
				nxt_state = ST_RUN;
				done_ev = 1'b1;
			end
		end
		ST_RUN: begin
			if (power_bad) begin
				nxt_state = ST_HOLD;
			end else if (pin_req) begin
				nxt_state = ST_DELAY;
				nxt_cause = CAUSE_PIN;
				nxt_cnt = dly_load(xtal_enable_option, 1'b1);
			end else if (watchdog_timeout && watchdog_action_option) begin
				nxt_state = ST_DELAY;
				nxt_cause = CAUSE_WDT;
				nxt_cnt = dly_load(xtal_enable_option, 1'b1);
			end else if (on_chip_debugger_rst_req) begin
				nxt_state = ST_DELAY;
				nxt_cause = CAUSE_POR;
				nxt_cnt = dly_load(xtal_enable_option, 1'b1);
				clr_ev = 1'b1;
			end else if (watchdog_timeout) begin
				irq_ev = 1'b1;
			end else if (stop_req) begin
				nxt_state = ST_STOP;
			end
		end
		ST_STOP: begin
			if (power_bad) begin
				nxt_state = ST_HOLD;
			end else if (pin_req || !dbg_s2_ff) begin
				nxt_state = ST_DELAY;
				nxt_cause = pin_req ? CAUSE_PIN : CAUSE_POR;
				nxt_cnt = dly_load(xtal_enable_option, 1'b1);
			end else if (watchdog_timeout) begin
				nxt_state = ST_RECOVER;
				nxt_cause = CAUSE_SMR_WDT;
				nxt_cnt = dly_load(xtal_enable_option, 1'b0);
			end else if (gpio_edge) begin
				nxt_state = ST_RECOVER;
				nxt_cause = CAUSE_SMR;
				nxt_cnt = dly_load(xtal_enable_option, 1'b0);
			end
		end
		ST_RECOVER: begin
			if (power_bad) begin
				nxt_state = ST_HOLD;
			end else if (!cnt_zero) begin
				nxt_cnt = cnt_ff - 16'h0001;
			end else begin
				nxt_state = ST_RUN;
				smr_done = 1'b1;
				// mask own drive while sync drains
				nxt_settle = 2'(PIN_SETTLE_CYC);
				irq_ev = cause_ff.watchdog_flag & ~watchdog_action_option;
			end
		end
		default: begin
			nxt_state = ST_HOLD;
		end
		endcase
	end

	assign nxt_pin_cnt = (pin_mask || !pin_low) ? 2'h0 :
		(pin_cnt_ff == 2'(PIN_MIN_CYC)) ? pin_cnt_ff : pin_cnt_ff + 2'h1;

	// set on completion; set wins over read-clear
	always_comb begin
		nxt_flags = stat_rd ? CAUSE_NONE : flags_ff;
		if (done_ev || smr_done) begin
			nxt_flags = cause_ff;
		end else if (irq_ev) begin
			nxt_flags = CAUSE_WDT;
		end
	end

	// ========================================
	// sequencer registers
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			state_ff <= ST_HOLD;
			cause_ff <= CAUSE_POR;
			cnt_ff <= 16'h0000;
			pin_cnt_ff <= 2'h0;
			settle_ff <= 2'h0;
			flags_ff <= CAUSE_NONE;
		end else begin
			state_ff <= nxt_state;
			cause_ff <= nxt_cause;
			cnt_ff <= nxt_cnt;
			pin_cnt_ff <= nxt_pin_cnt;
			settle_ff <= nxt_settle;
			flags_ff <= nxt_flags;
		end
	end

	// outputs from next state, registered
	wire nxt_sys = (nxt_state == ST_HOLD) | (nxt_state == ST_DELAY) |
		(nxt_state == ST_PINWAIT);
	// drive pin low for internal causes
	wire nxt_drive = ((nxt_state == ST_HOLD) |
		((nxt_state == ST_DELAY) & (nxt_cause != CAUSE_PIN))) |
		((nxt_state == ST_RECOVER) & ind_en_ff);
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			cpu_rst <= 1'b1;
			periph_rst <= 1'b1;
			rst_pin_n_oe <= 1'b1;
			dbg_req_clr <= 1'b0;
			vector_fetch <= 1'b0;
			osc_ipo_select <= 1'b0;
			wdt_ctl_update <= 1'b0;
			wdt_irq <= 1'b0;
			port_input_enable <= 1'b0;
			port_capture <= 1'b0;
			in_stop <= 1'b0;
		end else begin
			cpu_rst <= nxt_sys | (nxt_state == ST_RECOVER);
			periph_rst <= nxt_sys;
			rst_pin_n_oe <= nxt_drive;
			dbg_req_clr <= clr_ev;
			vector_fetch <= done_ev | smr_done;
			osc_ipo_select <= done_ev | smr_done;
			wdt_ctl_update <= smr_done;
			wdt_irq <= irq_ev;
			// ports off in stop, capture at end
			port_input_enable <= (nxt_state == ST_RUN);
			port_capture <= smr_done;
			in_stop <= (nxt_state == ST_STOP);
		end
	end
	assign rst_pin_n_o = 1'b0;
	assign vector_addr = START_VECTOR;

	// ========================================
	// Wishbone slave, one wait state
	// flag field at bits 7..4, low bits zero
	wire [31:0] rd_mux = hit_stat ? {24'h000000, flags_ff, 4'h0} :
		hit_ctrl ? {31'h00000000, ind_en_ff} : 32'h00000000;
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			ack_ff <= 1'b0;
			dat_ff <= 32'h00000000;
			ind_en_ff <= 1'b0;
		end else begin
			ack_ff <= wb_req;
			dat_ff <= wb_req ? rd_mux : 32'h00000000;
			if (ctrl_wr) begin
				ind_en_ff <= wb_dat_i[CTRL_IND_BIT];
			end
		end
	end
	assign wb_ack_o = ack_ff;
	assign wb_dat_o = dat_ff;

	// ========================================
	// checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	property p_power_hold;
		power_bad |=> cpu_rst && state_ff == ST_HOLD;
	endproperty
	a_power_hold: assert property (p_power_hold)
		else $error("supply low without reset");

	property p_full_delay;
		$rose(state_ff == ST_DELAY) && $past(state_ff) == ST_HOLD
			|-> cnt_ff == dly_load(xtal_enable_option, 1'b1);
	endproperty
	a_full_delay: assert property (p_full_delay)
		else $error("power-up delay not full length");

	property p_por_flag;
		$past(done_ev) && $past(cause_ff) == CAUSE_POR
			|-> flags_ff.por_flag;
	endproperty
	a_por_flag: assert property (p_por_flag)
		else $error("power-on flag not set");

	property p_wdt_reset;
		state_ff == ST_RUN && !power_bad && !pin_req &&
			watchdog_timeout && watchdog_action_option
			|=> state_ff == ST_DELAY && cause_ff == CAUSE_WDT;
	endproperty
	a_wdt_reset: assert property (p_wdt_reset)
		else $error("watchdog reset not taken");

	property p_pin_hold;
		state_ff == ST_PINWAIT && pin_low |=> state_ff != ST_RUN;
	endproperty
	a_pin_hold: assert property (p_pin_hold)
		else $error("left reset with pin low");

	property p_pin_glitch;
		state_ff == ST_RUN && !pin_mask && $rose(pin_low) ##1 pin_low
			##1 !pin_low |=> state_ff != ST_DELAY || cause_ff != CAUSE_PIN;
	endproperty
	a_pin_glitch: assert property (p_pin_glitch)
		else $error("short pin pulse caused reset");

	property p_drive;
		state_ff == ST_DELAY && cause_int |-> rst_pin_n_oe;
	endproperty
	a_drive: assert property (p_drive)
		else $error("pin not driven during internal reset");

	property p_smr_flag;
		smr_done |=> flags_ff.stop_flag ##1 wdt_ctl_update == 1'b0;
	endproperty
	a_smr_flag: assert property (p_smr_flag)
		else $error("stop flag not set after recovery");

	property p_periph_kept;
		state_ff == ST_RECOVER |-> !periph_rst && cpu_rst;
	endproperty
	a_periph_kept: assert property (p_periph_kept)
		else $error("recovery touched peripherals");

	property p_rd_clear;
		stat_rd && !done_ev && !smr_done && !irq_ev
			|=> flags_ff == CAUSE_NONE ##1 !wb_ack_o || wb_req;
	endproperty
	a_rd_clear: assert property (p_rd_clear)
		else $error("status read did not clear flags");

	c_wdt_smr: cover property (smr_done && cause_ff == CAUSE_SMR_WDT);
	c_gpio_smr: cover property (smr_done && cause_ff == CAUSE_SMR);
	c_pin_rst: cover property (done_ev && cause_ff == CAUSE_PIN);
	c_dbg_rst: cover property (dbg_req_clr);

endmodule : rst_ctrl

// file: dv/ext_reset_partner.sv
// neighbour part sharing the open-drain reset line, line has a pull-up
// assumes pull_go is a one-cycle pulse with pull_len already valid
`timescale 1ns/1ns
module ext_reset_partner (
	input wire logic clk_sys,
	input wire logic pull_go,
	input wire logic [15:0] pull_len,
	input wire logic dut_o,
	input wire logic dut_oe,
	output logic pin_n
);
	// ========================================
	// low-time counter
	logic [15:0] left_ff = 16'h0000;

	always_ff @(posedge clk_sys) begin
		if (pull_go) begin
			left_ff <= pull_len;
		end else if (left_ff != 16'h0000) begin
			left_ff <= left_ff - 16'h0001;
		end
	end

	// wired low from either side, pull-up when released
	assign pin_n = ((dut_oe && !dut_o) || left_ff != 16'h0000) ? 1'h0 : 1'h1;
endmodule : ext_reset_partner

// file: dv/testbench.sv
// self-checking bench for the reset and stop-recovery sequencer
// assumes rst_ctrl_pkg compiled first; debugger bit modelled here
`timescale 1ns/1ns
module testbench;
	import rst_ctrl_pkg::*;
	// ========================================
	// settings and signals
	localparam int XTAL = 40;
	localparam int FULL = IPO_START_CYC + BASE_DLY_CYC;
	localparam int SLACK = 16;
	logic clk_sys = 1'h0;
	logic sys_rst = 1'h1;
	logic wb_cyc = 1'h0;
	logic wb_we = 1'h0;
	logic [11:0] wb_adr = 12'h000;
	logic [31:0] wb_wdat = 32'h0;
	logic bo = 1'h0;
	logic bo_en = 1'h1;
	logic por = 1'h1;
	logic wdt_opt = 1'h1;
	logic xtal = 1'h0;
	logic wdt_to = 1'h0;
	logic dbg_req = 1'h0;
	logic stop = 1'h0;
	logic dbg_pin = 1'h1;
	logic [7:0] gpio = 8'h00;
	logic pull_go = 1'h0;
	logic [15:0] pull_len = 16'h0000;
	logic [31:0] wb_rdat;
	logic [15:0] vec_a;
	logic wb_ack, pin_n, pin_o, pin_oe, cpu_rst, periph_rst, dbg_clr;
	logic vec_f, osc_sel, wdt_irq, port_en, port_cap, in_stop;
	logic wcu;
	int n_fail = 0;
	int check_count = 0;
	int cyc_n = 0;
	int n_vec = 0;
	int n_osc = 0;
	int n_cap = 0;
	int n_clr = 0;
	int n_irq = 0;
	int n_per = 0;
	int n_wcu = 0;

	rst_ctrl #(.XTAL_DELAY_CYC(XTAL), .GPIO_N(8)) i_rst_ctrl (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc),
		.wb_stb_i(wb_cyc), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
		.wb_sel_i(4'hF), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
		.wb_ack_o(wb_ack), .por_ok(por), .brown_out_detect(bo),
		.brown_out_stop_enable_option(bo_en),
		.watchdog_action_option(wdt_opt), .xtal_enable_option(xtal),
		.watchdog_timeout(wdt_to), .on_chip_debugger_rst_req(dbg_req),
		.stop_req(stop), .debug_pin(dbg_pin), .rst_pin_n_i(pin_n),
		.rst_pin_n_o(pin_o), .rst_pin_n_oe(pin_oe), .gpio_in(gpio),
		.gpio_smr_en(8'h08), .cpu_rst(cpu_rst), .periph_rst(periph_rst),
		.dbg_req_clr(dbg_clr), .vector_fetch(vec_f), .vector_addr(vec_a),
		.osc_ipo_select(osc_sel), .wdt_ctl_update(wcu), .wdt_irq(wdt_irq),
		.port_input_enable(port_en), .port_capture(port_cap),
		.in_stop(in_stop));

	ext_reset_partner i_ext_reset_partner (.clk_sys(clk_sys),
		.pull_go(pull_go), .pull_len(pull_len), .dut_o(pin_o),
		.dut_oe(pin_oe), .pin_n(pin_n));

	// ========================================
	// clock, pulse tally, debugger bit, timeout
	initial begin
		forever #4 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys) begin
		cyc_n <= cyc_n + 1;
		n_vec <= n_vec + int'(vec_f === 1'h1);
		n_osc <= n_osc + int'(osc_sel === 1'h1);
		n_cap <= n_cap + int'(port_cap === 1'h1);
		n_clr <= n_clr + int'(dbg_clr === 1'h1);
		n_irq <= n_irq + int'(wdt_irq === 1'h1);
		n_per <= n_per + int'(periph_rst === 1'h1);
		n_wcu <= n_wcu + int'(wcu === 1'h1);
		if (dbg_clr === 1'h1) dbg_req <= 1'h0;
		if (cyc_n == 30000) begin
			n_fail++;
			give_verdict();
		end
	end

	// ========================================
	// compares and verdict
	task automatic check_val(string nm, logic [31:0] got, logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask : check_val

	task automatic check_bit(string nm, logic got, logic exp);
		check_val(nm, {31'h0, got}, {31'h0, exp});
	endtask : check_bit

	task automatic check_range(string nm, int got, int lo, int hi);
		check_count++;
		if (got < lo || got > hi) begin
			n_fail++;
			$display("MISMATCH %s expected %0d..%0d seen %0d", nm, lo, hi, got);
		end
	endtask : check_range

	task automatic give_verdict();
		if (n_fail == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : give_verdict

	// ========================================
	// drivers
	task automatic wb(input logic w, input logic [11:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		@(posedge clk_sys);
		wb_cyc <= 1'h1;
		wb_we <= w;
		wb_adr <= a;
		wb_wdat <= wd;
		do @(posedge clk_sys); while (wb_ack !== 1'h1);
		rd = wb_rdat;
		wb_cyc <= 1'h0;
		wb_we <= 1'h0;
	endtask : wb

	task automatic cycles(int n);
		repeat (n) @(negedge clk_sys);
	endtask : cycles

	task automatic wait_rst(input logic v, output int n);
		n = 0;
		do begin
			@(negedge clk_sys);
			n++;
		end while (cpu_rst !== v && n < 2000);
	endtask : wait_rst

	task automatic kick_wdt();
		@(posedge clk_sys);
		wdt_to <= 1'h1;
		@(posedge clk_sys);
		wdt_to <= 1'h0;
	endtask : kick_wdt

	task automatic kick_stop();
		@(posedge clk_sys);
		stop <= 1'h1;
		@(posedge clk_sys);
		stop <= 1'h0;
		cycles(4);
	endtask : kick_stop

	task automatic pull(int n);
		@(posedge clk_sys);
		pull_len <= 16'(n);
		pull_go <= 1'h1;
		@(posedge clk_sys);
		pull_go <= 1'h0;
	endtask : pull

	task automatic expect_seq(logic [7:0] st, int lo, logic own);
		int n;
		logic [31:0] d;
		wait_rst(1'h1, n);
		if (own) check_bit("pin_wire", pin_n, 1'h0);
		wait_rst(1'h0, n);
		check_range("hold_len", n, lo, lo + SLACK);
		wb(1'h0, RSTAT_ADDR, 32'h0, d);
		check_val("status", d, {24'h0, st});
	endtask : expect_seq

	// ========================================
	// scenarios
	task automatic t_power();
		logic [31:0] d;
		expect_seq(8'h80, FULL, 1'h1);
		check_range("vectors", n_vec, 1, 1);
		check_val("vector", {16'h0, vec_a}, 32'h0002);
		wb(1'h0, RSTAT_ADDR, 32'h0, d);
		check_val("reread", d, 32'h0);
		wb(1'h1, RSTAT_ADDR, 32'hFF, d);
		wb(1'h0, RSTAT_ADDR, 32'h0, d);
		check_val("ro_write", d, 32'h0);
		wb(1'h0, 12'h100, 32'h0, d);
		check_val("unmapped", d, 32'h0);
	endtask : t_power

	task automatic t_wdt();
		int k;
		logic [31:0] d;
		kick_wdt();
		expect_seq(8'h20, FULL, 1'h1);
		k = n_irq;
		@(posedge clk_sys);
		wdt_opt <= 1'h0;
		kick_wdt();
		cycles(20);
		check_bit("no_reset", cpu_rst, 1'h0);
		check_range("irqs", n_irq - k, 1, 1);
		wb(1'h0, RSTAT_ADDR, 32'h0, d);
		check_val("irq_status", d, 32'h20);
	endtask : t_wdt

	task automatic t_pin();
		int n;
		logic [31:0] d;
		pull(2);
		cycles(20);
		check_bit("short_pulse", cpu_rst, 1'h0);
		pull(5);
		expect_seq(8'h10, FULL, 1'h0);
		pull(800);
		cycles(790);
		check_bit("pin_held", cpu_rst, 1'h1);
		wait_rst(1'h0, n);
		check_range("release", n, 10, 10 + SLACK);
		wb(1'h0, RSTAT_ADDR, 32'h0, d);
		check_val("long_pin", d, 32'h10);
	endtask : t_pin

	// second pass drives the pin in recovery and masks brown-out in stop
	task automatic t_stop_gpio();
		int v;
		int c;
		int o;
		int p;
		int u;
		logic [31:0] d;
		for (int e = 0; e < 2; e++) begin
			v = n_vec;
			c = n_cap;
			o = n_osc;
			p = n_per;
			u = n_wcu;
			wb(1'h1, CTRL_ADDR, 32'(e), d);
			wb(1'h0, CTRL_ADDR, 32'h0, d);
			check_val("ctrl", d, 32'(e));
			kick_stop();
			check_bit("in_stop", in_stop, 1'h1);
			check_bit("port_off", port_en, 1'h0);
			@(posedge clk_sys);
			gpio[0] <= ~gpio[0];
			bo_en <= (e == 0);
			bo <= 1'(e);
			cycles(10);
			check_bit("masked_pin", in_stop, 1'h1);
			@(posedge clk_sys);
			gpio[3] <= ~gpio[3];
			bo <= 1'h0;
			expect_seq(8'h40, BASE_DLY_CYC, 1'(e));
			check_range("vector", n_vec - v, 1, 1);
			check_range("osc_sel", n_osc - o, 1, 1);
			check_range("capture", n_cap - c, 1, 1);
			check_range("periph_kept", n_per - p, 0, 0);
			check_range("ctl_update", n_wcu - u, 1, 1);
		end
		wb(1'h1, CTRL_ADDR, 32'h0, d);
		@(posedge clk_sys);
		bo_en <= 1'h1;
	endtask : t_stop_gpio

	task automatic t_stop_wdt();
		int k;
		int u;
		@(posedge clk_sys);
		xtal <= 1'h1;
		wdt_opt <= 1'h0;
		k = n_irq;
		u = n_wcu;
		kick_stop();
		kick_wdt();
		expect_seq(8'h60, XTAL, 1'h0);
		cycles(4);
		check_range("late_irq", n_irq - k, 1, 1);
		check_range("wdt_update", n_wcu - u, 1, 1);
		@(posedge clk_sys);
		wdt_opt <= 1'h1;
	endtask : t_stop_wdt

	task automatic t_brown();
		@(posedge clk_sys);
		bo <= 1'h1;
		por <= 1'h0;
		cycles(30);
		check_bit("brown_hold", cpu_rst, 1'h1);
		@(posedge clk_sys);
		bo <= 1'h0;
		cycles(30);
		check_bit("below_por", cpu_rst, 1'h1);
		@(posedge clk_sys);
		por <= 1'h1;
		expect_seq(8'h80, IPO_START_CYC + XTAL, 1'h1);
		@(posedge clk_sys);
		xtal <= 1'h0;
	endtask : t_brown

	task automatic t_dbg();
		int c;
		c = n_clr;
		@(posedge clk_sys);
		dbg_req <= 1'h1;
		expect_seq(8'h80, FULL, 1'h1);
		check_range("req_clear", n_clr - c, 1, 1);
		kick_stop();
		@(posedge clk_sys);
		dbg_pin <= 1'h0;
		repeat (4) @(posedge clk_sys);
		dbg_pin <= 1'h1;
		expect_seq(8'h80, FULL - 4, 1'h1);
	endtask : t_dbg

	// ========================================
	// main sequence
	initial begin
		repeat (10) @(posedge clk_sys);
		sys_rst <= 1'h0;
		t_power();
		t_wdt();
		t_pin();
		t_stop_gpio();
		t_stop_wdt();
		t_brown();
		t_dbg();
		give_verdict();
	end
endmodule : testbench
